// [logic/msc_sideband.sv]
`timescale 1ns/1ps
`include "msc_params.svh"
// How it works
// - Serial bus access is enabled only while module_select_n is sampled low.
// - Host reaches the memory map over serial clock and data lines.
// - Reset low longer than minimum pulse restores all settings to defaults.
// - Completion shown by asserting attention with not-ready flag cleared.
// - Power-up raises the completion attention without any reset pulse.
// - Low-power request input caps the module power mode.
// - Module pulls the presence line low once inserted.
// - Attention is driven low for faults or critical status.
// - Attention is only pulled low, never driven high.
// - Error correction is built in and enabled for full reach.
module msc_sideband (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Pins from host
  input  wire logic                   module_select_n,
  input  wire logic                   module_reset_n,
  input  wire logic                   low_power_request,
  // Serial bus engine side
  input  wire logic                   serial_access_req,
  output logic                        serial_enable,
  // Fault and status events from module logic
  input  wire logic [`MSC_FLAG_W-1:0] fault_event,
  // Host has read or cleared flags (from memory map logic)
  input  wire logic [`MSC_FLAG_W-1:0] flag_clear,
  input  wire logic                   reset_done_clear,
  // Status to memory map
  output logic [`MSC_FLAG_W-1:0]      flag_status,
  output logic                        data_not_ready,
  output logic                        reset_done_flag,
  output logic                        settings_default,
  output logic                        fec_enable,
  output logic                        low_power_mode,
  // Pins to host
  output logic                        presence_oe,
  output logic                        presence_out,
  output logic                        attention_oe,
  output logic                        attention_out
);
  logic sel_n_s;
  logic rst_n_s;
  logic lpm_s;

  msc_sync u_sync_sel (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (module_select_n),
    .dout    (sel_n_s)
  );
  msc_sync u_sync_rst (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (module_reset_n),
    .dout    (rst_n_s)
  );
  msc_sync u_sync_lpm (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (low_power_request),
    .dout    (lpm_s)
  );

  msc_pkg::msc_state_t        st_q;
  msc_pkg::msc_state_t        st_d;
  logic [`MSC_CNT_W-1:0]      cnt_q;
  logic [`MSC_CNT_W-1:0]      cnt_d;
  logic [`MSC_FLAG_W-1:0]     flags_q;
  logic [`MSC_FLAG_W-1:0]     flags_d;
  logic                       done_q;
  logic                       done_d;
  logic                       lpm_q;
  logic                       lpm_d;

  // Reset pulse width and init timing; sys_rst lands in RESET so power-up also completes
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    done_d = done_q;
    unique case (st_q)
      msc_pkg::MSC_ST_RESET: begin
        if (rst_n_s) begin
          st_d  = msc_pkg::MSC_ST_INIT;
          cnt_d = '0;
        end
      end
      msc_pkg::MSC_ST_INIT: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == `MSC_CNT_W'(`MSC_INIT_CYC - 1)) begin
          st_d   = msc_pkg::MSC_ST_READY;
          done_d = 1'b1;
          // Fresh count, so a reset held across init still needs a full pulse
          cnt_d  = '0;
        end
      end
      msc_pkg::MSC_ST_READY: begin
        if (!rst_n_s) begin
          if (cnt_q != `MSC_CNT_W'(`MSC_RESET_MIN_CYC)) begin
            cnt_d = cnt_q + 1'b1;
          end
        end else begin
          cnt_d = '0;
        end
        // Short glitches are filtered; only a full pulse resets
        if (!rst_n_s && cnt_q == `MSC_CNT_W'(`MSC_RESET_MIN_CYC - 1)) begin
          st_d   = msc_pkg::MSC_ST_RESET;
          done_d = 1'b0;
        end
      end
    endcase
    if (st_q == msc_pkg::MSC_ST_READY && reset_done_clear && st_d == msc_pkg::MSC_ST_READY) begin
      done_d = 1'b0;
    end
  end

  // Flags: set wins over clear
  always_comb begin
    flags_d = (flags_q & ~flag_clear) | fault_event;
    if (st_q != msc_pkg::MSC_ST_READY) begin
      flags_d = `MSC_FLAGS_RST;
    end
    lpm_d = lpm_s;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q    <= msc_pkg::MSC_ST_RESET;
      cnt_q   <= '0;
      flags_q <= `MSC_FLAGS_RST;
      done_q  <= 1'b0;
      lpm_q   <= 1'b1;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      flags_q <= flags_d;
      done_q  <= done_d;
      lpm_q   <= lpm_d;
    end
  end

  // Assertion helper: cycles the synced reset pin has been low while ready, saturating
  logic [`MSC_CNT_W-1:0]      low_run_q;
  logic [`MSC_CNT_W-1:0]      low_run_d;

  always_comb begin
    low_run_d = low_run_q;
    if (st_q != msc_pkg::MSC_ST_READY || rst_n_s) begin
      low_run_d = '0;
    end else if (low_run_q != `MSC_CNT_W'(`MSC_RESET_MIN_CYC)) begin
      low_run_d = low_run_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_run_q <= '0;
    end else begin
      low_run_q <= low_run_d;
    end
  end

  assign serial_enable    = ~sel_n_s & serial_access_req;
  assign flag_status      = flags_q;
  assign data_not_ready   = (st_q != msc_pkg::MSC_ST_READY);
  assign reset_done_flag  = done_q;
  assign settings_default = (st_q == msc_pkg::MSC_ST_RESET);
  assign fec_enable       = 1'b1;
  assign low_power_mode   = lpm_q;
  assign presence_oe      = 1'b1;
  assign presence_out     = 1'b0;
  assign attention_out    = 1'b0;
  assign attention_oe     = done_q | (|flags_q);

  chk_select_gates_bus: assert property (@(posedge clk) disable iff (sys_rst)
    sel_n_s |-> !serial_enable) else $error("bus enabled while deselected");
  chk_attn_only_low: assert property (@(posedge clk) disable iff (sys_rst)
    attention_oe |-> !attention_out) else $error("attention driven high");
  chk_done_ready: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(done_q) |-> !data_not_ready && attention_oe) else $error("done without ready");
  chk_powerup_done: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(data_not_ready) |-> done_q) else $error("ready without completion");
  chk_long_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == msc_pkg::MSC_ST_READY && !rst_n_s && low_run_q == `MSC_CNT_W'(`MSC_RESET_MIN_CYC - 1))
    |=> settings_default && flags_q == `MSC_FLAGS_RST) else $error("reset not taken");
  chk_glitch_filtered: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == msc_pkg::MSC_ST_READY && low_run_q < `MSC_CNT_W'(`MSC_RESET_MIN_CYC - 1)) |=> !settings_default)
    else $error("short reset pulse taken");
  chk_flags_in_reset: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q != msc_pkg::MSC_ST_READY) |=> flag_status == `MSC_FLAGS_RST) else $error("event kept in reset");
  chk_fault_attn: assert property (@(posedge clk) disable iff (sys_rst)
    (|fault_event && st_q == msc_pkg::MSC_ST_READY && st_d == msc_pkg::MSC_ST_READY) |=> attention_oe)
    else $error("fault not signalled");
  chk_attn_release: assert property (@(posedge clk) disable iff (sys_rst)
    (!done_q && flags_q == '0) |-> !attention_oe) else $error("attention stuck");
  chk_lpm_follow: assert property (@(posedge clk) disable iff (sys_rst)
    ##3 low_power_mode == $past(low_power_request, 3)) else $error("low power not followed");
  chk_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == msc_pkg::MSC_ST_READY && st_d == msc_pkg::MSC_ST_READY)
    |=> (flag_status & $past(fault_event)) == $past(fault_event)) else $error("flag event lost");
  chk_flag_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == msc_pkg::MSC_ST_READY && st_d == msc_pkg::MSC_ST_READY)
    |=> (flag_status & $past(flag_clear & ~fault_event)) == '0) else $error("flag not cleared");
  chk_done_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == msc_pkg::MSC_ST_READY && st_d == msc_pkg::MSC_ST_READY && reset_done_clear)
    |=> !reset_done_flag) else $error("completion not released");
  chk_presence_low: assert property (@(posedge clk) disable iff (sys_rst)
    presence_oe && !presence_out) else $error("presence not pulled low");

  // Reset completion walk: leave reset, still not ready at the last init cycle, then post completion
  localparam int init_last = `MSC_INIT_CYC - 1;
  sequence seq_enter_init;
    (st_q == msc_pkg::MSC_ST_RESET) ##1 (st_q == msc_pkg::MSC_ST_INIT);
  endsequence
  sequence seq_init_complete;
    ##init_last data_not_ready ##1 (!data_not_ready && reset_done_flag && attention_oe);
  endsequence
  chk_init_walk: assert property (@(posedge clk) disable iff (sys_rst)
    seq_enter_init |-> seq_init_complete) else $error("completion not posted");
endmodule

// [logic/msc_params.svh]
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH
// Minimum reset pulse on the module reset pin, in ns, and its cycle count at 100 MHz
`define MSC_CLK_PERIOD_NS      10
`define MSC_RESET_MIN_NS       2000
`define MSC_RESET_MIN_CYC      ((`MSC_RESET_MIN_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)
// Time from reset release until the module is ready, in ns
`define MSC_INIT_NS            1000
`define MSC_INIT_CYC           (`MSC_INIT_NS / `MSC_CLK_PERIOD_NS)
`define MSC_CNT_W              10
`define MSC_FLAG_W             8
// Reset values
`define MSC_FLAGS_RST          8'h00
`define MSC_CTRL_RST           8'h00
`define MSC_FEC_EN_BIT         0
`endif

// [logic/msc_pkg.sv]
package msc_pkg;
  typedef enum logic [1:0] {
    MSC_ST_RESET,
    MSC_ST_INIT,
    MSC_ST_READY
  } msc_state_t;
endpackage

// [logic/msc_sync.sv]
`timescale 1ns/1ps
module msc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Level crossing
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  // Reset high: inactive for the active-low pins, low power for the mode pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule

// [dv/msc_host_model.sv]
`timescale 1ns/1ps
module msc_host_model (
  // Module pin drivers
  input  wire logic attention_oe,
  input  wire logic attention_out,
  input  wire logic presence_oe,
  input  wire logic presence_out,
  // Board wire levels
  output logic      attention_pin,
  output logic      presence_pin
);
  // Board pull-ups, module may only pull low
  assign attention_pin = attention_oe ? attention_out : 1'b1;
  assign presence_pin  = presence_oe ? presence_out : 1'b1;
endmodule

// [dv/test_msc_sideband.sv]
`timescale 1ns/1ps
module test_msc_sideband;
  logic       clk, sys_rst, sel_n, rst_n, lpr, sreq, dclr;
  logic [7:0] fev, fclr, fst;
  logic       sen, dnr, done, sdef, fec, lpm, p_oe, p_out, a_oe, a_out, a_pin, p_pin;
  int         fail_count, tests_run;
  msc_sideband msc_sideband_inst (.clk(clk), .sys_rst(sys_rst), .module_select_n(sel_n),
    .module_reset_n(rst_n), .low_power_request(lpr), .serial_access_req(sreq),
    .serial_enable(sen), .fault_event(fev), .flag_clear(fclr), .reset_done_clear(dclr),
    .flag_status(fst), .data_not_ready(dnr), .reset_done_flag(done), .settings_default(sdef),
    .fec_enable(fec), .low_power_mode(lpm), .presence_oe(p_oe), .presence_out(p_out),
    .attention_oe(a_oe), .attention_out(a_out));
  msc_host_model msc_host_model_inst (.attention_oe(a_oe), .attention_out(a_out),
    .presence_oe(p_oe), .presence_out(p_out), .attention_pin(a_pin), .presence_pin(p_pin));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait, init takes about 100 cycles
  task automatic wait_done;
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #60000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    sys_rst = 1;
    sel_n = 1;
    rst_n = 1;
    lpr = 1;
    sreq = 1;
    dclr = 0;
    fev = 8'h00;
    fclr = 8'h00;
    cyc(10);
    sys_rst = 0;
    cyc(1);
    check("lpm_reset", 8'h01, lpm);
    check("init_not_ready", 8'h01, dnr);
    wait_done();
    check("done", 8'h01, done);
    check("not_ready", 8'h00, dnr);
    check("attention", 8'h00, a_pin);
    check("presence", 8'h00, p_pin);
    check("fec", 8'h01, fec);
    check("serial_off", 8'h00, sen);
    dclr = 1;
    cyc(1);
    dclr = 0;
    cyc(2);
    check("attention_rel", 8'h01, a_pin);
    $display("Test power-up done");
    sel_n = 0;
    cyc(4);
    check("serial_on", 8'h01, sen);
    sreq = 0;
    cyc(1);
    check("serial_idle", 8'h00, sen);
    lpr = 0;
    cyc(4);
    check("lpm_off", 8'h00, lpm);
    lpr = 1;
    cyc(4);
    check("lpm_on", 8'h01, lpm);
    $display("Test pins done");
    fev = 8'h08;
    cyc(1);
    fev = 8'h00;
    cyc(2);
    check("attention_flt", 8'h00, a_pin);
    sreq = 1;
    cyc(1);
    check("cause_read", 8'h01, sen);
    check("flags", 8'h08, fst);
    fev = 8'h10;
    fclr = 8'h18;
    cyc(1);
    check("set_wins", 8'h10, fst);
    fev = 8'h00;
    fclr = 8'h10;
    cyc(1);
    fclr = 8'h00;
    cyc(2);
    check("flags_clr", 8'h00, fst);
    check("attention_clr", 8'h01, a_pin);
    $display("Test fault done");
    // Too short a pulse must be ignored
    rst_n = 0;
    cyc(100);
    rst_n = 1;
    cyc(5);
    check("short_rst", 8'h00, dnr);
    rst_n = 0;
    cyc(250);
    check("defaults", 8'h01, sdef);
    check("rst_not_ready", 8'h01, dnr);
    fev = 8'hFF;
    cyc(1);
    fev = 8'h00;
    check("reset_discard", 8'h00, fst);
    rst_n = 1;
    wait_done();
    check("rst_done", 8'h01, done);
    check("rst_ready", 8'h00, dnr);
    check("rst_attention", 8'h00, a_pin);
    $display("Test reset done");
    report_and_stop();
  end
endmodule
